/* File: core/fss_pkg.sv */
// Package of constants for the flash status and soft reset controller
package fss_pkg;
   // ********************************
   // Register map of the AHB slave
   // ********************************
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_ADDR = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_POLL = 4'hc;
   localparam int CMD_OP_LSB = 16;
   localparam int CMD_BUSY_BIT = 31;
   // ********************************
   // Flash command codes and addresses
   // ********************************
   localparam logic [15:0] FL_RESET = 16'h00f0;
   localparam logic [15:0] FL_STAT_RD = 16'h0070;
   localparam logic [15:0] FL_STAT_CLR = 16'h0071;
   localparam logic [25:0] FL_UNLOCK_ADDR = 26'h555;
   localparam logic [25:0] FL_BASE_ADDR = 26'h0;
   // ********************************
   // Status and polling word fields
   // ********************************
   localparam int ST_READY = 7;
   localparam int PL_TIMEOUT = 5;
   localparam logic [15:0] ST_MASK = 16'h00fe;
   localparam logic [15:0] PL_MASK = 16'h00ee;
   localparam logic [15:0] ST_RESULT_MASK = 16'h007e;
   // ********************************
   // Strobe timing
   // ********************************
   localparam int CLK_PS = 5000;
   localparam int T_WP_NS = 50;
   localparam int T_ACC_NS = 90;
   localparam int T_REC_NS = 20;
   localparam logic [4:0] WP_CYC = 5'((T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS);
   localparam logic [4:0] ACC_CYC =
      5'((T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
   localparam logic [4:0] REC_CYC =
      5'((T_REC_NS * 1000 + CLK_PS - 1) / CLK_PS);
   // ********************************
   // Types
   // ********************************
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_RESET = 3'b001,
      OP_STATUS = 3'b010,
      OP_CLEAR = 3'b011,
      OP_SUSP = 3'b100,
      OP_POLL = 3'b101
   } fss_op_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_WLO = 3'b001,
      S_WHI = 3'b010,
      S_RLO = 3'b011,
      S_RHI = 3'b100
   } fss_state_e;
endpackage : fss_pkg

/* File: core/fss_ctrl.sv */
// Host controller for flash status reads, polling and soft reset
`timescale 1ns/1ps
`default_nettype none
module fss_ctrl
   import fss_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Flash pins
   output logic [25:0] fl_addr,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in
);
   // ********************************
   // Registers
   // ********************************
   fss_state_e state_r;
   fss_op_e op_r;
   logic [4:0] cnt_r;
   logic [15:0] data_r;
   logic [25:0] addr_r;
   logic [15:0] status_r;
   logic [15:0] poll_r;
   logic wr_pend_r;
   logic [3:0] wa_r;
   logic go, cnt_done;
   logic [15:0] st_word;

   // ********************************
   // AHB slave
   // ********************************
   // Zero wait state, always OKAY; read data staged at the address phase;
   // addresses above the register map read 0 and ignore writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wa_r <= 4'h0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= hsel && htrans[1] && hready && hwrite &&
            (haddr[31:4] == 28'h0000000);
         if (hsel && htrans[1] && hready) begin
            wa_r <= haddr[3:0];
            if (!hwrite) begin
               case (haddr[3:0] | {4{haddr[31:4] != 28'h0000000}})
                  OFS_CMD: hrdata <= {(state_r != S_IDLE), 12'h000,
                     op_r, data_r};
                  OFS_ADDR: hrdata <= {6'h00, addr_r};
                  OFS_STATUS: hrdata <= {16'h0000, status_r};
                  OFS_POLL: hrdata <= {16'h0000, poll_r};
                  default: hrdata <= 32'h00000000;
               endcase
            end
         end
      end
   end

   // A command write while a sequence runs is dropped
   assign go = wr_pend_r && (wa_r == OFS_CMD) && (state_r == S_IDLE);
   assign cnt_done = (cnt_r == 5'h00);
   // Status word with reserved bits masked and 6:1 hidden while busy
   assign st_word = fl_dq_in[ST_READY] ? (fl_dq_in & ST_MASK) :
      (fl_dq_in & (ST_MASK & ~ST_RESULT_MASK));

   // Target address register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r <= 26'h0;
      end else if (wr_pend_r && (wa_r == OFS_ADDR)) begin
         addr_r <= hwdata[25:0];
      end
   end

   // ********************************
   // Flash bus sequencer
   // ********************************
   // Each access is a timed strobe low phase and a recovery high phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= S_IDLE;
         op_r <= OP_NONE;
         cnt_r <= 5'h00;
         data_r <= 16'h0000;
         status_r <= 16'h0000;
         poll_r <= 16'h0000;
         fl_addr <= 26'h0;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
         fl_dq_out <= 16'h0000;
         fl_dq_oe <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (go) begin
                  op_r <= fss_op_e'(hwdata[CMD_OP_LSB +: 3]);
                  data_r <= hwdata[15:0];
                  fl_ce_n <= 1'b0;
                  case (fss_op_e'(hwdata[CMD_OP_LSB +: 3]))
                     OP_RESET: begin
                        fl_addr <= FL_BASE_ADDR;
                        fl_dq_out <= FL_RESET;
                     end
                     OP_STATUS: begin
                        fl_addr <= FL_UNLOCK_ADDR;
                        fl_dq_out <= FL_STAT_RD;
                     end
                     OP_CLEAR: begin
                        fl_addr <= FL_UNLOCK_ADDR;
                        fl_dq_out <= FL_STAT_CLR;
                     end
                     default: begin
                        fl_addr <= addr_r;
                        fl_dq_out <= hwdata[15:0];
                     end
                  endcase
                  if (fss_op_e'(hwdata[CMD_OP_LSB +: 3]) == OP_POLL) begin
                     fl_oe_n <= 1'b0;
                     cnt_r <= ACC_CYC;
                     state_r <= S_RLO;
                  end else begin
                     fl_we_n <= 1'b0;
                     fl_dq_oe <= 1'b1;
                     cnt_r <= WP_CYC;
                     state_r <= S_WLO;
                  end
               end
            end
            S_WLO: begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_done) begin
                  fl_we_n <= 1'b1;
                  fl_ce_n <= 1'b1;
                  cnt_r <= REC_CYC;
                  state_r <= S_WHI;
               end
            end
            S_WHI: begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_done) begin
                  fl_dq_oe <= 1'b0;
                  if (op_r == OP_STATUS || op_r == OP_SUSP &&
                      fl_dq_out == FL_STAT_RD) begin
                     // Overlay aliases every address; read one word
                     fl_ce_n <= 1'b0;
                     fl_oe_n <= 1'b0;
                     cnt_r <= ACC_CYC;
                     state_r <= S_RLO;
                  end else if (op_r == OP_SUSP) begin
                     // Suspend written; now read status until ready
                     fl_addr <= FL_UNLOCK_ADDR;
                     fl_dq_out <= FL_STAT_RD;
                     fl_ce_n <= 1'b0;
                     fl_we_n <= 1'b0;
                     fl_dq_oe <= 1'b1;
                     cnt_r <= WP_CYC;
                     state_r <= S_WLO;
                  end else begin
                     // Reset and clear finish within the write itself
                     state_r <= S_IDLE;
                  end
               end
            end
            S_RLO: begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_done) begin
                  fl_ce_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  if (op_r == OP_POLL) begin
                     poll_r <= fl_dq_in & PL_MASK;
                  end else begin
                     status_r <= st_word;
                  end
                  cnt_r <= REC_CYC;
                  state_r <= S_RHI;
               end
            end
            S_RHI: begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_done) begin
                  if (op_r == OP_SUSP && !status_r[ST_READY]) begin
                     fl_ce_n <= 1'b0;
                     fl_we_n <= 1'b0;
                     fl_dq_oe <= 1'b1;
                     cnt_r <= WP_CYC;
                     state_r <= S_WLO;
                  end else if (op_r == OP_POLL && poll_r[PL_TIMEOUT]) begin
                     // Timed out: reset is the only way to clear it
                     op_r <= OP_RESET;
                     fl_addr <= FL_BASE_ADDR;
                     fl_dq_out <= FL_RESET;
                     fl_ce_n <= 1'b0;
                     fl_we_n <= 1'b0;
                     fl_dq_oe <= 1'b1;
                     cnt_r <= WP_CYC;
                     state_r <= S_WLO;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_poll_reset;
      (state_r == S_RHI && cnt_done && op_r == OP_POLL && poll_r[PL_TIMEOUT])
         |=> (fl_dq_out == FL_RESET && !fl_we_n && op_r == OP_RESET);
   endproperty
   a_poll_reset: assert property (p_poll_reset)
      else $error("timeout poll not followed by reset");

   property p_one_read;
      (state_r == S_RLO && cnt_done && op_r == OP_STATUS)
         |=> (fl_oe_n && fl_ce_n) [*2] ##0 (state_r == S_RHI);
   endproperty
   a_one_read: assert property (p_one_read)
      else $error("status overlay read not ended");

   property p_upper_masked;
      status_r[15:8] == 8'h00 && status_r[0] == 1'b0;
   endproperty
   a_upper_masked: assert property (p_upper_masked)
      else $error("reserved status bits not masked");

   property p_busy_hides;
      !status_r[ST_READY] |-> (status_r & ST_RESULT_MASK) == 16'h0000;
   endproperty
   a_busy_hides: assert property (p_busy_hides)
      else $error("status bits shown while busy");

   property p_susp_ready;
      (state_r == S_RHI && op_r == OP_SUSP) ##1 (state_r == S_IDLE)
         |-> status_r[ST_READY];
   endproperty
   a_susp_ready: assert property (p_susp_ready)
      else $error("suspend finished before ready");

   property p_poll_masked;
      (poll_r & ~PL_MASK) == 16'h0000;
   endproperty
   a_poll_masked: assert property (p_poll_masked)
      else $error("undefined polling bits not masked");

   c_status: cover property (state_r == S_RHI && op_r == OP_STATUS);
   c_susp_loop: cover property (state_r == S_RHI && op_r == OP_SUSP &&
      !status_r[ST_READY]);
   c_poll_to: cover property (state_r == S_RHI && op_r == OP_POLL &&
      poll_r[PL_TIMEOUT]);
endmodule : fss_ctrl
`default_nettype wire

/* File: bench/fss_flash_model.sv */
// Behavioural model of the flash status overlay, polling and soft reset
`timescale 1ns/1ps
`default_nettype none
module fss_flash_model
   import fss_pkg::*;
#(
   parameter logic [15:0] SUSP_CMD = 16'h00b0,
   parameter logic [15:0] RESUME_CMD = 16'h0030,
   parameter logic [15:0] PROG_CMD = 16'h00a0,
   parameter logic [15:0] ECC_CMD = 16'h0075,
   parameter logic [15:0] ECC_WORD = 16'h0006,
   parameter logic [15:0] UND_WORD = 16'h00ca
)(
   // Flash pins
   input wire logic [25:0] fl_addr,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   input wire logic [15:0] fl_dq_out,
   input wire logic fl_dq_oe,
   output logic [15:0] fl_dq_in,
   // Scenario controls
   input wire logic busy,
   input wire logic tmo_set,
   input wire logic res_set,
   input wire logic [6:0] res_in
);
   logic [6:0] st_r = 7'h00;
   logic [6:0] cap_r = 7'h40;
   logic [15:0] last_r = 16'h0000;
   logic [7:0] rd_r = 8'h00;
   logic ovl_r = 1'b0;
   logic tmo_r = 1'b0;
   logic ecc_r = 1'b0;
   logic und_r = 1'b0;
   logic [25:0] sa_r = 26'h0;
   int susp_r = 0;
   logic [15:0] word;
   // Word on the bus: status overlay, ECC word, undefined-state word, polling overlay or array data
   always_comb begin
      if (ovl_r) begin
         word = {rd_r, cap_r, rd_r[0]};
      end else if (ecc_r) begin
         word = ECC_WORD;
      end else if (und_r) begin
         word = UND_WORD;
      end else if (busy || tmo_r) begin
         word = {rd_r, 2'b01, tmo_r, rd_r[1], 3'b101, rd_r[0]};
      end else begin
         word = fl_addr[15:0] ^ 16'h5a5a;
      end
   end
   // Released bus shows the inverse of the last word
   assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? word : ~last_r;
   // End of a read leaves the status overlay
   always @(posedge fl_oe_n) begin
      last_r = word;
      rd_r = rd_r + 8'h01;
      ovl_r = 1'b0;
   end
   // Result bits forced by a scenario
   always @(posedge res_set) st_r = res_in;
   always @(posedge tmo_set) tmo_r = 1'b1;
   // Command decode at the rising write strobe, no extra latency
   always @(posedge fl_we_n) begin
      if (fl_dq_oe !== 1'b1) begin
         // Host not driving the data lines: nothing is latched
      end else if (fl_dq_out == FL_STAT_RD) begin
         if (susp_r == 1) st_r[6] = 1'b1;
         if (susp_r > 0) susp_r--;
         cap_r = (busy || susp_r > 0) ? {1'b0, rd_r[5:0]} :
            {1'b1, st_r[6:1]};
         ovl_r = 1'b1;
      end else if (fl_dq_out == FL_RESET) begin
         if (!busy) begin
            tmo_r = 1'b0;
            ecc_r = 1'b0;
            und_r = 1'b0;
            if (!st_r[3]) st_r = st_r & 7'h4c;
         end
      end else if (fl_dq_out == FL_STAT_CLR) begin
         st_r = st_r & 7'h44;
      end else if (fl_dq_out == SUSP_CMD) begin
         susp_r = 2;
         sa_r = fl_addr;
      end else if (fl_dq_out == RESUME_CMD) begin
         st_r[6] = 1'b0;
      end else if (fl_dq_out == PROG_CMD) begin
         if (st_r[6] && fl_addr == sa_r) st_r[4] = 1'b1;
      end else if (fl_dq_out == ECC_CMD) begin
         ecc_r = 1'b1;
      end else begin
         und_r = 1'b1;
      end
   end
endmodule : fss_flash_model
`default_nettype wire

/* File: bench/flash_status_and_soft_reset_bench.sv */
// Self-checking bench for the flash status and soft reset controller
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_soft_reset_bench;
   import fss_pkg::*;
   localparam logic [25:0] ADR = 26'h3ffa0c3;
   localparam logic [15:0] ARR = (ADR[15:0] ^ 16'h5a5a) & PL_MASK;
   localparam logic [15:0] PRG = 16'h00a0;
   localparam logic [15:0] ECC_C = 16'h0075;
   localparam logic [15:0] ECC_W = 16'h0006;
   localparam logic [15:0] UND_W = 16'h00ca;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic busy = 1'b0;
   logic tmo_set = 1'b0;
   logic res_set = 1'b0;
   logic [6:0] res_in = 7'h00;
   logic hreadyout, hresp, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
   logic [31:0] hrdata;
   logic [25:0] fl_addr;
   logic [15:0] fl_dq_out, fl_dq_in;
   wire logic hready;
   int bad_count = 0;
   int checks = 0;
   assign hready = hreadyout;
   // ********************************
   // Clock, design and device model
   // ********************************
   always #2.5 hclk = ~hclk;
   fss_ctrl u_fss_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fl_addr(fl_addr),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in));
   fss_flash_model #(.PROG_CMD(PRG), .ECC_CMD(ECC_C), .ECC_WORD(ECC_W),
      .UND_WORD(UND_W)) u_fss_flash_model (.fl_addr(fl_addr),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
      .busy(busy), .tmo_set(tmo_set), .res_set(res_set), .res_in(res_in));
   // ********************************
   // Shared tasks
   // ********************************
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Single AHB word transfer, address phase then data phase
   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask : bus
   // Issue one operation and wait for the busy bit to drop
   task automatic op(input logic [2:0] o, input logic [15:0] d);
      logic [31:0] q;
      int n;
      bus(1'b1, 32'(OFS_CMD), {13'h0, o, d}, q);
      n = 0;
      q = 32'hffffffff;
      while (q[CMD_BUSY_BIT] !== 1'b0 && n < 1000) begin
         bus(1'b0, 32'(OFS_CMD), 32'h0, q);
         n++;
      end
      chk("op_done", 32'd0, 32'(n >= 1000));
   endtask : op
   task automatic rdchk(input string nm, input logic [31:0] a,
      input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, 32'(a), 32'h0, q);
      chk(nm, {16'h0, e}, q);
   endtask : rdchk
   task automatic stchk(input string nm, input logic [15:0] e);
      op(3'd2, 16'h0000);
      rdchk(nm, OFS_STATUS, e);
   endtask : stchk
   task automatic pchk(input string nm, input logic [15:0] e);
      op(3'd5, 16'h0000);
      rdchk(nm, OFS_POLL, e);
   endtask : pchk
   task automatic load(input logic [6:0] v);
      res_in <= v;
      res_set <= 1'b1;
      @(posedge hclk);
      res_set <= 1'b0;
      @(posedge hclk);
   endtask : load
   // ********************************
   // Scenarios
   // ********************************
   task automatic t_reset;
      logic [31:0] q;
      rdchk("cmd_reset", OFS_CMD, 16'h0000);
      bus(1'b1, 32'(OFS_ADDR), {6'h0, ADR}, q);
      rdchk("unmapped", 32'h10 + 32'(OFS_ADDR), 16'h0000);
      stchk("status_reset", 16'h0080);
      pchk("array_after_status", ARR);
   endtask : t_reset
   task automatic t_clear;
      load(7'h32);
      stchk("result_bits", 16'h00b2);
      op(3'd1, FL_RESET);
      stchk("reset_clears", 16'h0080);
      load(7'h3a);
      op(3'd1, FL_RESET);
      stchk("reset_abort_kept", 16'h00ba);
      op(3'd3, FL_STAT_CLR);
      stchk("clear_results", 16'h0080);
      load(7'h44);
      op(3'd3, FL_STAT_CLR);
      stchk("clear_keeps_susp", 16'h00c4);
      op(3'd1, FL_RESET);
      stchk("reset_keeps_susp", 16'h00c4);
   endtask : t_clear
   task automatic t_busy;
      load(7'h32);
      busy <= 1'b1;
      stchk("busy_status", 16'h0000);
      op(3'd1, FL_RESET);
      pchk("poll_busy", 16'h004a);
      busy <= 1'b0;
      stchk("reset_ignored", 16'h00b2);
   endtask : t_busy
   task automatic t_tmo;
      tmo_set <= 1'b1;
      @(posedge hclk);
      tmo_set <= 1'b0;
      pchk("poll_timeout", 16'h006a);
      pchk("read_after_timeout", ARR);
   endtask : t_tmo
   task automatic t_susp;
      op(3'd4, 16'h00b0);
      rdchk("suspend_ready", OFS_STATUS, 16'h00c0);
      op(3'd4, PRG);
      rdchk("program_suspended_fails", OFS_STATUS, 16'h00d0);
      op(3'd4, 16'h0030);
      rdchk("resume_clears", OFS_STATUS, 16'h0090);
   endtask : t_susp
   task automatic t_ovl;
      op(3'd0, ECC_C);
      pchk("ecc_overlay", ECC_W & PL_MASK);
      op(3'd1, FL_RESET);
      pchk("ecc_exit", ARR);
      op(3'd0, 16'h00ab);
      pchk("undefined_state", UND_W & PL_MASK);
      op(3'd1, FL_RESET);
      pchk("undefined_exit", ARR);
   endtask : t_ovl
   task automatic summarize;
      $display("Checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   // Watchdog against a hung handshake
   initial begin
      #(60000 * 5);
      bad_count++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_clear();
      t_busy();
      t_tmo();
      t_susp();
      t_ovl();
      summarize();
   end
endmodule : flash_status_and_soft_reset_bench
`default_nettype wire
